// File: dirq_flag_bank.sv
// Bank of synchronised status flags, each live or latched on a rising edge.
`include "dirq_params.svh"
module dirq_flag_bank #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [N-1:0] raw,
  input wire logic [N-1:0] latch_mode,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flag
);

  // ****************************************************************
  // Per-bit synchroniser, filter and flag
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic val_r;
      logic val_nxt;
      logic rise;

      // Three stages; the first is read only by the second.
      always_ff @(posedge clk) begin
        if (!nrst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= raw[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end

      // A change is accepted only once the second and third stages agree.
      assign val_nxt = (s2_r == s3_r) ? s3_r : val_r;
      assign rise = val_nxt & ~val_r;

      // Filtered live level.
      always_ff @(posedge clk) begin
        if (!nrst) begin
          val_r <= 1'b0;
        end else begin
          val_r <= val_nxt;
        end
      end

      // Live mode follows the level; latch mode sets on a rising edge, and the set wins over a clear.
      always_ff @(posedge clk) begin
        if (!nrst) begin
          flag[i] <= `DIRQ_RST_FLAG;
        end else if (!latch_mode[i]) begin
          flag[i] <= val_nxt;
        end else if (rise) begin
          flag[i] <= 1'b1;
        end else if (clr[i]) begin
          flag[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// File: dirq_monitor.sv
// Port-level assertions for the interrupt status block.
`include "dirq_params.svh"

module dirq_monitor #(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [3:0] pstrb,
  input wire dirq_pkg::dirq_word_t pwdata,
  input wire dirq_pkg::dirq_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serdes_pll_lock_live,
  input wire logic dac0_pattern_check_fail,
  input wire logic dac1_pattern_check_fail,
  input wire logic dac0_power_threshold_error,
  input wire logic dac0_blanking_complete,
  input wire logic dac0_frame_align_locked,
  input wire logic dac0_frame_align_rotated,
  input wire logic [LANES-1:0] lane_fifo_full,
  input wire logic [LANES-1:0] lane_fifo_empty,
  input wire logic link_enable,
  input wire logic irq_n
);
  import dirq_pkg::*;

  localparam logic [11:0] A_S0 = {`DIRQ_IDX_STATUS0, 2'b00};
  localparam logic [11:0] A_S1 = {`DIRQ_IDX_STATUS1, 2'b00};
  localparam logic [11:0] A_S2 = {`DIRQ_IDX_STATUS2, 2'b00};
  localparam logic [11:0] A_LINK = {`DIRQ_IDX_LINK_CTRL, 2'b00};
  localparam logic [11:0] A_FULL = {`DIRQ_IDX_LANE_FULL, 2'b00};
  localparam logic [11:0] A_EMPTY = {`DIRQ_IDX_LANE_EMPTY, 2'b00};

  // ********
  // Sequences and properties
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_full_steady;
    $stable(lane_fifo_full) [*6];
  endsequence
  sequence s_empty_steady;
    $stable(lane_fifo_empty) [*6];
  endsequence

  property p_ready_next;
    s_setup |=> pready && psel && penable;
  endproperty
  property p_quiet;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  property p_stat0_resv;
    pready && !pwrite && paddr == A_S0 |-> (prdata[7:0] & ~`DIRQ_IMPL0) == 8'h00 && prdata[31:8] == 24'h0;
  endproperty
  property p_stat1_resv;
    pready && !pwrite && paddr == A_S1 |-> prdata[7:3] == 5'h00 && !prdata[1] && prdata[31:8] == 24'h0;
  endproperty
  property p_stat2_resv;
    pready && !pwrite && paddr == A_S2 |-> (prdata[7:0] & ~`DIRQ_IMPL2) == 8'h00 && prdata[31:8] == 24'h0;
  endproperty
  property p_full_seen;
    s_full_steady ##0 (s_setup and (!pwrite && paddr == A_FULL)) |=> prdata[LANES-1:0] == lane_fifo_full;
  endproperty
  property p_empty_seen;
    s_empty_steady ##0 (s_setup and (!pwrite && paddr == A_EMPTY)) |=> prdata[LANES-1:0] == lane_fifo_empty;
  endproperty
  property p_irq_reset;
    $rose(nrst) |-> irq_n [*2];
  endproperty
  property p_link_follow;
    pready && pwrite && pstrb[0] && !pslverr && paddr == A_LINK |-> ##2 link_enable == $past(pwdata[0], 2);
  endproperty

  // ********
  // Assertions
  // ********
  a_ready_next: assert property (p_ready_next) else $error("no ready one cycle after setup");
  a_quiet: assert property (p_quiet) else $error("read data or error outside ready");
  a_stat0_resv: assert property (p_stat0_resv) else $error("reserved bit set in first status");
  a_stat1_resv: assert property (p_stat1_resv) else $error("reserved bit set in second status");
  a_stat2_resv: assert property (p_stat2_resv) else $error("reserved bit set in third status");
  a_full_seen: assert property (p_full_seen) else $error("lane full readback wrong");
  a_empty_seen: assert property (p_empty_seen) else $error("lane empty readback wrong");
  a_irq_reset: assert property (p_irq_reset) else $error("interrupt active after reset");
  a_link_follow: assert property (p_link_follow) else $error("link enable does not follow write");
endmodule

bind dirq_top dirq_monitor #(.LANES(LANES)) dirq_monitor_inst (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serdes_pll_lock_live(serdes_pll_lock_live), .dac0_pattern_check_fail(dac0_pattern_check_fail),
  .dac1_pattern_check_fail(dac1_pattern_check_fail), .dac0_power_threshold_error(dac0_power_threshold_error),
  .dac0_blanking_complete(dac0_blanking_complete), .dac0_frame_align_locked(dac0_frame_align_locked),
  .dac0_frame_align_rotated(dac0_frame_align_rotated), .lane_fifo_full(lane_fifo_full),
  .lane_fifo_empty(lane_fifo_empty), .link_enable(link_enable), .irq_n(irq_n));

// File: dirq_params.svh
// Register indices, field positions, reset values and timing counts of the interrupt status block.
`ifndef DIRQ_PARAMS_SVH
`define DIRQ_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define DIRQ_IDX_STATUS0 10'h023
`define DIRQ_IDX_STATUS1 10'h024
`define DIRQ_IDX_STATUS2 10'h025
`define DIRQ_IDX_MODE0 10'h01f
`define DIRQ_IDX_MODE1 10'h020
`define DIRQ_IDX_MODE2 10'h021
`define DIRQ_IDX_MASK0 10'h040
`define DIRQ_IDX_MASK1 10'h041
`define DIRQ_IDX_MASK2 10'h042
`define DIRQ_IDX_LINK_CTRL 10'h300
`define DIRQ_IDX_LANE_FULL 10'h30c
`define DIRQ_IDX_LANE_EMPTY 10'h30d

// ****************************************************************
// Bit positions inside the status, mode, mask and link control bytes
// ****************************************************************
`define DIRQ_B_PLL_LOCK 2
`define DIRQ_B_FIFO_ERR 1
`define DIRQ_B_DAC1_PATTERN_CHECK_FAIL 2
`define DIRQ_B_DAC0_PATTERN_CHECK_FAIL 0
`define DIRQ_B_PDP 7
`define DIRQ_B_BLANK 5
`define DIRQ_B_ALIGN_LOCK 3
`define DIRQ_B_ALIGN_ROT 2
`define DIRQ_B_LINK_EN 0

// ****************************************************************
// Implemented-bit masks per byte; all other bits read as zero
// ****************************************************************
`define DIRQ_IMPL0 8'h06
`define DIRQ_IMPL1 8'h05
`define DIRQ_IMPL2 8'hac

// ****************************************************************
// Reset values
// ****************************************************************
`define DIRQ_RST_MODE 8'h00
`define DIRQ_RST_MASK 8'hff
`define DIRQ_RST_LINK 1'b0
`define DIRQ_RST_FLAG 1'b0

// ****************************************************************
// Timing: the slave answers one cycle after the setup cycle
// ****************************************************************
`define DIRQ_APB_WAIT 1

`endif

// File: dirq_pkg.sv
// Types shared by the interrupt status block.
package dirq_pkg;

  // One-hot states of the register bus slave.
  typedef enum logic [1:0] {
    DIRQ_ST_IDLE = 2'b01,
    DIRQ_ST_ACK = 2'b10
  } dirq_apb_e;

  // One byte of a status, mode or mask register.
  typedef logic [7:0] dirq_byte_t;

  // One APB data word.
  typedef logic [31:0] dirq_word_t;

endpackage

// File: dirq_top.sv
// Interrupt status latches of the dual converter with an APB register slave.
//
// Summary of operation
// - SERDES PLL lock flag: live, or latched interrupt.
// - Writing one clears latched flag; zero keeps.
// - Lane error on any lane FIFO full/empty.
// - Lane error persists until link disable, re-enable.
// - Per-lane full and empty in two registers.
// - DAC1 pattern failure in second register, bit 2.
// - DAC0 pattern failure in second register, bit 0.
// - DAC0 power threshold error in third, bit 7.
// - DAC0 blanking complete in third, bit 5.
// - DAC0 frame alignment locked in third, bit 3.
// - DAC0 frame alignment rotated in third, bit 2.
// - Mode bit one latches; zero shows live status.
`include "dirq_params.svh"

module dirq_top #(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [3:0] pstrb,
  input wire dirq_pkg::dirq_word_t pwdata,
  output dirq_pkg::dirq_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serdes_pll_lock_live,
  input wire logic dac0_pattern_check_fail,
  input wire logic dac1_pattern_check_fail,
  input wire logic dac0_power_threshold_error,
  input wire logic dac0_blanking_complete,
  input wire logic dac0_frame_align_locked,
  input wire logic dac0_frame_align_rotated,
  input wire logic [LANES-1:0] lane_fifo_full,
  input wire logic [LANES-1:0] lane_fifo_empty,
  output logic link_enable,
  output logic irq_n
);
  import dirq_pkg::*;

  // ****************************************************************
  // Declarations and the order of flags inside the internal eight-flag vectors
  // ****************************************************************
  localparam int F_PLL = 0, F_FIFO = 1, F_DAC0_PATTERN_CHECK_FAIL = 2, F_DAC1_PATTERN_CHECK_FAIL = 3, F_PDP = 4, F_BLANK = 5, F_LOCK = 6, F_ROT = 7;
  dirq_apb_e state_r;
  dirq_byte_t mode0_r, mode1_r, mode2_r;
  dirq_byte_t mask0_r, mask1_r, mask2_r;
  logic link_en_r, fifo_err_r;
  logic [7:0] raw_vec, mode_vec, mask_vec, clr_vec, flag_vec, pend_vec;
  logic [2*LANES-1:0] lane_raw, lane_live;
  logic [LANES-1:0] lane_full_live, lane_empty_live;
  logic [9:0] idx;
  logic hit, wr_en;
  dirq_word_t rd_data;
  dirq_byte_t st0, st1, st2, wbyte;
  logic serdes_pll_locked_flag, serdes_pll_locked_latch_mode, lane_buffer_error_flag;

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  // Word index of the access; the two low address bits must be zero.
  assign idx = paddr[11:2];
  assign wbyte = pwdata[7:0];

  // Address hit on any implemented register.
  always_comb begin
    hit = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      case (idx)
        `DIRQ_IDX_STATUS0, `DIRQ_IDX_STATUS1, `DIRQ_IDX_STATUS2: hit = 1'b1;
        `DIRQ_IDX_MODE0, `DIRQ_IDX_MODE1, `DIRQ_IDX_MODE2: hit = 1'b1;
        `DIRQ_IDX_MASK0, `DIRQ_IDX_MASK1, `DIRQ_IDX_MASK2: hit = 1'b1;
        `DIRQ_IDX_LINK_CTRL, `DIRQ_IDX_LANE_FULL, `DIRQ_IDX_LANE_EMPTY: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // A write takes effect at the edge that completes the access phase.
  assign wr_en = (state_r == DIRQ_ST_ACK) & psel & penable & pwrite & hit & pstrb[0];

  // ****************************************************************
  // Bus slave state machine and answer
  // ****************************************************************
  // Setup cycle is answered with pready in the next cycle; unmapped addresses get pslverr.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= DIRQ_ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      // The answer stands one cycle; it drops in every state unless a setup cycle in the idle state raises it.
      state_r <= DIRQ_ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      case (state_r)
        DIRQ_ST_IDLE: begin
          if (psel && !penable) begin
            state_r <= DIRQ_ST_ACK;
            pready <= 1'b1;
            pslverr <= ~hit;
            prdata <= (pwrite || !hit) ? 32'h0 : rd_data;
          end
        end
        DIRQ_ST_ACK: state_r <= DIRQ_ST_IDLE;
        default: state_r <= DIRQ_ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Status byte packing
  // ****************************************************************

  // First status byte: PLL lock and lane error.
  always_comb begin
    st0 = 8'h0;
    st0[`DIRQ_B_PLL_LOCK] = serdes_pll_locked_flag;
    st0[`DIRQ_B_FIFO_ERR] = lane_buffer_error_flag;
  end

  // Second status byte: pattern checks, reserved bits stay zero.
  always_comb begin
    st1 = 8'h0;
    st1[`DIRQ_B_DAC1_PATTERN_CHECK_FAIL] = flag_vec[F_DAC1_PATTERN_CHECK_FAIL];
    st1[`DIRQ_B_DAC0_PATTERN_CHECK_FAIL] = flag_vec[F_DAC0_PATTERN_CHECK_FAIL];
  end

  // Third status byte: DAC0 events, reserved bits stay zero.
  always_comb begin
    st2 = 8'h0;
    st2[`DIRQ_B_PDP] = flag_vec[F_PDP];
    st2[`DIRQ_B_BLANK] = flag_vec[F_BLANK];
    st2[`DIRQ_B_ALIGN_LOCK] = flag_vec[F_LOCK];
    st2[`DIRQ_B_ALIGN_ROT] = flag_vec[F_ROT];
  end

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Narrow registers sit in the low bits; upper bits read as zero.
  always_comb begin
    rd_data = 32'h0;
    case (idx)
      `DIRQ_IDX_STATUS0: rd_data = {24'h0, st0};
      `DIRQ_IDX_STATUS1: rd_data = {24'h0, st1};
      `DIRQ_IDX_STATUS2: rd_data = {24'h0, st2};
      `DIRQ_IDX_MODE0: rd_data = {24'h0, mode0_r};
      `DIRQ_IDX_MODE1: rd_data = {24'h0, mode1_r};
      `DIRQ_IDX_MODE2: rd_data = {24'h0, mode2_r};
      `DIRQ_IDX_MASK0: rd_data = {24'h0, mask0_r};
      `DIRQ_IDX_MASK1: rd_data = {24'h0, mask1_r};
      `DIRQ_IDX_MASK2: rd_data = {24'h0, mask2_r};
      `DIRQ_IDX_LINK_CTRL: rd_data = {31'h0, link_en_r};
      `DIRQ_IDX_LANE_FULL: rd_data = {{(32-LANES){1'b0}}, lane_full_live};
      `DIRQ_IDX_LANE_EMPTY: rd_data = {{(32-LANES){1'b0}}, lane_empty_live};
      default: rd_data = 32'h0;
    endcase
  end

  // ****************************************************************
  // Mode and mask registers
  // ****************************************************************

  // Mode bytes; only implemented bits are writable.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode0_r <= `DIRQ_RST_MODE;
      mode1_r <= `DIRQ_RST_MODE;
      mode2_r <= `DIRQ_RST_MODE;
    end else if (wr_en) begin
      if (idx == `DIRQ_IDX_MODE0) begin
        mode0_r <= wbyte & `DIRQ_IMPL0;
      end
      if (idx == `DIRQ_IDX_MODE1) begin
        mode1_r <= wbyte & `DIRQ_IMPL1;
      end
      if (idx == `DIRQ_IDX_MODE2) begin
        mode2_r <= wbyte & `DIRQ_IMPL2;
      end
    end
  end

  // Mask bytes; a one lets the latched flag reach the interrupt line.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask0_r <= `DIRQ_RST_MASK & `DIRQ_IMPL0;
      mask1_r <= `DIRQ_RST_MASK & `DIRQ_IMPL1;
      mask2_r <= `DIRQ_RST_MASK & `DIRQ_IMPL2;
    end else if (wr_en) begin
      if (idx == `DIRQ_IDX_MASK0) begin
        mask0_r <= wbyte & `DIRQ_IMPL0;
      end
      if (idx == `DIRQ_IDX_MASK1) begin
        mask1_r <= wbyte & `DIRQ_IMPL1;
      end
      if (idx == `DIRQ_IDX_MASK2) begin
        mask2_r <= wbyte & `DIRQ_IMPL2;
      end
    end
  end

  // Unpack mode and mask bytes into flag order.
  always_comb begin
    mode_vec = {mode2_r[`DIRQ_B_ALIGN_ROT], mode2_r[`DIRQ_B_ALIGN_LOCK], mode2_r[`DIRQ_B_BLANK],
                mode2_r[`DIRQ_B_PDP], mode1_r[`DIRQ_B_DAC1_PATTERN_CHECK_FAIL], mode1_r[`DIRQ_B_DAC0_PATTERN_CHECK_FAIL],
                mode0_r[`DIRQ_B_FIFO_ERR], mode0_r[`DIRQ_B_PLL_LOCK]};
    mask_vec = {mask2_r[`DIRQ_B_ALIGN_ROT], mask2_r[`DIRQ_B_ALIGN_LOCK], mask2_r[`DIRQ_B_BLANK],
                mask2_r[`DIRQ_B_PDP], mask1_r[`DIRQ_B_DAC1_PATTERN_CHECK_FAIL], mask1_r[`DIRQ_B_DAC0_PATTERN_CHECK_FAIL],
                mask0_r[`DIRQ_B_FIFO_ERR], mask0_r[`DIRQ_B_PLL_LOCK]};
  end

  // ****************************************************************
  // Write-one-to-clear pulses
  // ****************************************************************

  // A one in a status write clears that flag in latch mode; zeros leave flags alone.
  always_comb begin
    clr_vec = 8'h0;
    if (wr_en) begin
      case (idx)
        `DIRQ_IDX_STATUS0: begin
          clr_vec[F_PLL] = wbyte[`DIRQ_B_PLL_LOCK];
          clr_vec[F_FIFO] = wbyte[`DIRQ_B_FIFO_ERR];
        end
        `DIRQ_IDX_STATUS1: begin
          clr_vec[F_DAC1_PATTERN_CHECK_FAIL] = wbyte[`DIRQ_B_DAC1_PATTERN_CHECK_FAIL];
          clr_vec[F_DAC0_PATTERN_CHECK_FAIL] = wbyte[`DIRQ_B_DAC0_PATTERN_CHECK_FAIL];
        end
        `DIRQ_IDX_STATUS2: begin
          clr_vec[F_PDP] = wbyte[`DIRQ_B_PDP];
          clr_vec[F_BLANK] = wbyte[`DIRQ_B_BLANK];
          clr_vec[F_LOCK] = wbyte[`DIRQ_B_ALIGN_LOCK];
          clr_vec[F_ROT] = wbyte[`DIRQ_B_ALIGN_ROT];
        end
        default: clr_vec = 8'h0;
      endcase
    end
  end

  // ****************************************************************
  // Link control and lane error condition
  // ****************************************************************

  // Software link enable, driven out to the lane receiver.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      link_en_r <= `DIRQ_RST_LINK;
    end else if (wr_en && idx == `DIRQ_IDX_LINK_CTRL) begin
      link_en_r <= wbyte[`DIRQ_B_LINK_EN];
    end
  end

  // Lane error holds from the first full or empty until the link is disabled.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fifo_err_r <= 1'b0;
    end else if (!link_en_r) begin
      fifo_err_r <= 1'b0;
    end else if ((|lane_full_live) || (|lane_empty_live)) begin
      fifo_err_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Flag banks
  // ****************************************************************

  // Lane indications are synchronised and always shown live.
  assign lane_raw = {lane_fifo_empty, lane_fifo_full};
  assign lane_full_live = lane_live[LANES-1:0];
  assign lane_empty_live = lane_live[2*LANES-1:LANES];

  dirq_flag_bank #(
    .N(2*LANES)
  ) u_lane_bank (
    .clk(clk),
    .nrst(nrst),
    .raw(lane_raw),
    .latch_mode({(2*LANES){1'b0}}),
    .clr({(2*LANES){1'b0}}),
    .flag(lane_live)
  );

  // Event sources in flag order.
  assign raw_vec = {dac0_frame_align_rotated, dac0_frame_align_locked, dac0_blanking_complete,
                    dac0_power_threshold_error, dac1_pattern_check_fail, dac0_pattern_check_fail,
                    fifo_err_r, serdes_pll_lock_live};

  dirq_flag_bank #(
    .N(8)
  ) u_flag_bank (
    .clk(clk),
    .nrst(nrst),
    .raw(raw_vec),
    .latch_mode(mode_vec),
    .clr(clr_vec),
    .flag(flag_vec)
  );

  // Named views of the PLL and lane flags.
  assign serdes_pll_locked_flag = flag_vec[F_PLL];
  assign serdes_pll_locked_latch_mode = mode_vec[F_PLL];
  assign lane_buffer_error_flag = flag_vec[F_FIFO];

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  // Only flags in latch mode are pending; live flags never pull the line.
  assign pend_vec = flag_vec & mode_vec & mask_vec;

  // Line is low while any pending flag is set.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~((|pend_vec) |
                 (serdes_pll_locked_flag & serdes_pll_locked_latch_mode & mask_vec[F_PLL]));
    end
  end

  // Link enable output from its register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      link_enable <= `DIRQ_RST_LINK;
    end else begin
      link_enable <= link_en_r;
    end
  end

endmodule

// File: testbench.sv
// Self-checking bench for the interrupt status block, driven over APB.
`include "dirq_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dirq_pkg::*;

  logic clk, nrst, psel, penable, pwrite, pready, pslverr, link_enable, irq_n, err;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  dirq_word_t pwdata, prdata, rd;
  logic [6:0] ev;
  logic [7:0] full, empty, b;
  logic [9:0] i;
  int fail_count, checks_done;
  localparam logic [9:0] EV_IDX [7] = '{`DIRQ_IDX_STATUS0, `DIRQ_IDX_STATUS1, `DIRQ_IDX_STATUS1,
    `DIRQ_IDX_STATUS2, `DIRQ_IDX_STATUS2, `DIRQ_IDX_STATUS2, `DIRQ_IDX_STATUS2};
  localparam int EV_BIT [7] = '{`DIRQ_B_PLL_LOCK, `DIRQ_B_DAC1_PATTERN_CHECK_FAIL, `DIRQ_B_DAC0_PATTERN_CHECK_FAIL, `DIRQ_B_PDP, `DIRQ_B_BLANK,
    `DIRQ_B_ALIGN_LOCK, `DIRQ_B_ALIGN_ROT};
  localparam logic [7:0] IMPL [3] = '{`DIRQ_IMPL0, `DIRQ_IMPL1, `DIRQ_IMPL2};
  localparam logic [9:0] LNK = `DIRQ_IDX_LINK_CTRL;
  localparam logic [9:0] ST0 = `DIRQ_IDX_STATUS0;

  dirq_top #(.LANES(8)) dirq_top_inst (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serdes_pll_lock_live(ev[0]), .dac1_pattern_check_fail(ev[1]), .dac0_pattern_check_fail(ev[2]),
    .dac0_power_threshold_error(ev[3]), .dac0_blanking_complete(ev[4]), .dac0_frame_align_locked(ev[5]),
    .dac0_frame_align_rotated(ev[6]), .lane_fifo_full(full), .lane_fifo_empty(empty),
    .link_enable(link_enable), .irq_n(irq_n));

  // The clock toggles every 10 ns for a 50 MHz rate.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output dirq_word_t q,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // The wait for the answer ends when pready is seen high; if it never comes, only the watchdog ends it.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the next call from driving these signals again in the same time step.
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] x, input logic [7:0] d);
    apb(1'b1, {x, 2'b00}, d, rd, err);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic rc(input logic [9:0] x, input logic [7:0] e);
    apb(1'b0, {x, 2'b00}, 8'h00, rd, err);
    chk(rd, {24'h0, e});
  endtask

  task automatic ci(input logic e);
    chk({31'h0, irq_n}, {31'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The watchdog ends a hung run as a failure.
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    {psel, penable, pwrite, nrst, ev, full, empty} = '0;
    paddr = 12'h000;
    pstrb = 4'hf;
    pwdata = 32'h0;
    fail_count = 0;
    checks_done = 0;
    cyc(3);
    nrst <= 1'b1;
    @(posedge clk);
    ci(1'b1);
    for (logic [9:0] r = 0; r < 3; r++) begin
      rc(`DIRQ_IDX_MODE0 + r, `DIRQ_RST_MODE);
      rc(`DIRQ_IDX_MASK0 + r, `DIRQ_RST_MASK & IMPL[r]);
      rc(`DIRQ_IDX_STATUS0 + r, 8'h00);
    end
    // Unmapped and misaligned accesses answer with an error.
    apb(1'b0, 12'hffc, 8'h00, rd, err);
    chk({rd[31:1], err}, 32'h1);
    apb(1'b0, 12'h091, 8'h00, rd, err);
    chk({rd[31:1], err}, 32'h1);
    // A write without byte-0 strobe is ignored; reserved mode bits stay zero.
    pstrb <= 4'h0;
    wr(`DIRQ_IDX_MODE0, 8'h06);
    pstrb <= 4'hf;
    rc(`DIRQ_IDX_MODE0, 8'h00);
    wr(`DIRQ_IDX_MODE2, 8'hff);
    rc(`DIRQ_IDX_MODE2, IMPL[2]);
    wr(`DIRQ_IDX_MODE2, 8'h00);
    // Each event in live mode, then latched, masked and cleared.
    for (int k = 0; k < 7; k++) begin
      i = EV_IDX[k];
      b = 8'h01 << EV_BIT[k];
      ev[k] <= 1'b1;
      cyc(8);
      rc(i, b);
      ci(1'b1);
      ev[k] <= 1'b0;
      cyc(8);
      rc(i, 8'h00);
      wr(i - 10'h4, b);
      ev[k] <= 1'b1;
      cyc(8);
      ci(1'b0);
      ev[k] <= 1'b0;
      cyc(8);
      rc(i, b);
      wr(i, ~b);
      rc(i, b);
      wr(i + 10'h1d, 8'h00);
      cyc(2);
      ci(1'b1);
      wr(i + 10'h1d, 8'hff);
      cyc(2);
      ci(1'b0);
      wr(i, b);
      cyc(2);
      rc(i, 8'h00);
      ci(1'b1);
      wr(i - 10'h4, 8'h00);
    end
    // Lane buffer error: live persistence, link restart, latched by an empty lane.
    wr(LNK, 8'h01);
    rc(LNK, 8'h01);
    chk({31'h0, link_enable}, 32'h1);
    full[3] <= 1'b1;
    cyc(8);
    rc(`DIRQ_IDX_LANE_FULL, 8'h08);
    full[3] <= 1'b0;
    cyc(8);
    rc(ST0, 8'h02);
    ci(1'b1);
    wr(LNK, 8'h00);
    cyc(8);
    chk({31'h0, link_enable}, 32'h0);
    rc(ST0, 8'h00);
    wr(LNK, 8'h01);
    cyc(8);
    rc(ST0, 8'h00);
    wr(`DIRQ_IDX_MODE0, 8'h02);
    empty[5] <= 1'b1;
    cyc(12);
    rc(`DIRQ_IDX_LANE_EMPTY, 8'h20);
    ci(1'b0);
    empty[5] <= 1'b0;
    wr(LNK, 8'h00);
    cyc(8);
    rc(ST0, 8'h02);
    wr(ST0, 8'h02);
    cyc(2);
    rc(ST0, 8'h00);
    ci(1'b1);
    print_verdict();
  end
endmodule
